// file: ohc_pkg.sv
package ohc_pkg;

    // Register byte offsets
    localparam logic [11:0] OHC_CTRL_SET_OFS = 12'h050;
    localparam logic [11:0] OHC_CTRL_CLR_OFS = 12'h054;
    localparam logic [11:0] OHC_BASE_OFS     = 12'h064;

    // Offsets that live on the PHY-supplied clock
    localparam logic [11:0] OHC_PHY_LO1 = 12'h0DC;
    localparam logic [11:0] OHC_PHY_HI1 = 12'h0F0;
    localparam logic [11:0] OHC_PHY_LO2 = 12'h100;
    localparam logic [11:0] OHC_PHY_HI2 = 12'h11C;

    // Control register field positions
    localparam int OHC_BIT_LOWER_CFG = 23;
    localparam int OHC_BIT_PHY_ENH   = 22;
    localparam int OHC_BIT_LPS       = 19;
    localparam int OHC_BIT_POSTED    = 18;
    localparam int OHC_BIT_LINK_ON   = 17;
    localparam int OHC_BIT_SRST      = 16;

    // Self-ID base is 2K-byte aligned
    localparam int OHC_BASE_LSB = 11;
    localparam int OHC_BASE_W   = 32 - OHC_BASE_LSB;
    localparam int OHC_IDX_W    = OHC_BASE_LSB - 2;

    // Reset values and answers
    localparam logic        OHC_LOWER_CFG_RST = 1'b1;
    localparam logic [31:0] OHC_ALL_ONES      = 32'hFFFFFFFF;
    localparam logic [31:0] OHC_ZERO          = 32'h00000000;
    localparam logic [7:0]  OHC_SRST_CYCLES   = 8'h08;

    typedef enum logic [0:0] {
        OHC_SRST_IDLE,
        OHC_SRST_BUSY
    } ohc_srst_type;

    typedef struct packed {
        logic                  phy_sync1;
        logic                  phy_sync2;
        ohc_srst_type          srst_state;
        logic [7:0]            srst_cnt;
        logic                  lower_cfg;
        logic                  phy_enh;
        logic                  link_power_status;
        logic                  posted;
        logic                  link_on;
        logic [OHC_BASE_W-1:0] base;
        logic [31:0]           rd_data;
        logic                  abort;
    } ohc_state_type;

    typedef struct packed {
        logic                  active;
        logic [OHC_IDX_W-1:0]  idx;
        logic                  wr_valid;
        logic [31:0]           wr_addr;
    } ohc_sid_state_type;

endpackage

// file: ohc_selfid_if.sv
`timescale 1ns/100ps
interface ohc_selfid_if;
    import ohc_pkg::*;
    logic [OHC_BASE_W-1:0] base;
    logic                  enable;
    logic                  flush;
    logic                  start;
    logic                  q_valid;
    logic                  wr_valid;
    logic [31:0]           wr_addr;

    modport ctrl (output base, enable, flush, start, q_valid, input wr_valid, wr_addr);
    modport gen  (input base, enable, flush, start, q_valid, output wr_valid, wr_addr);
endinterface

// file: ohc_selfid_addr.sv
`timescale 1ns/100ps
module ohc_selfid_addr
    import ohc_pkg::*;
(
    // Clock and reset
    input  wire logic  i_ref_clk,
    input  wire logic  i_reset_n,
    // Link to the register bank
    ohc_selfid_if.gen  sid
);

    ohc_sid_state_type r;
    ohc_sid_state_type r_nxt;

    always_comb begin
        r_nxt          = r;
        r_nxt.wr_valid = 1'b0;
        if (sid.start) begin
            r_nxt.active = 1'b1;
            r_nxt.idx    = '0;
        end else if (sid.q_valid && r.active) begin
            r_nxt.wr_valid = 1'b1;
            r_nxt.wr_addr  = {sid.base, r.idx, 2'b00};
            r_nxt.idx      = r.idx + 1'b1;
            // Buffer is one aligned 2K page; stop rather than wrap over the header
            if (&r.idx) begin
                r_nxt.active = 1'b0;
            end
        end
        if (!sid.enable || sid.flush) begin
            r_nxt.active   = 1'b0;
            r_nxt.wr_valid = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign sid.wr_valid = r.wr_valid;
    assign sid.wr_addr  = r.wr_addr;

    chk_selfid_addr_base: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        sid.q_valid && r.active && !sid.start && sid.enable && !sid.flush
        |=> sid.wr_valid && sid.wr_addr[31:OHC_BASE_LSB] == $past(sid.base) && sid.wr_addr[1:0] == 2'b00)
        else $error("self-ID write address not inside the programmed buffer");

endmodule

// file: ohc_ctrl_regs.sv
// Summary of operation
// - Control bits 21 and 20 read zero.
// - Link-PHY traffic only while power status set.
// - PHY-domain access with clock off aborts.
// - Suppress option returns all ones instead.
// - Listed offset ranges belong to PHY clock.
// - Posted writes follow bit 18.
// - Hardware and software reset clear link enable.
// - Link off means no packet activity.
// - Software reset restores registers except the configured flag, flushes state.
// - Software reset bit reads one while busy.
// - Control bits 15 to 0 read zero.
// - Self-ID base keeps bits 31-11 only.
// - Self-ID packets written at programmed base.
// - Configured flag loads from serial EEPROM.
`timescale 1ns/100ps
module ohc_ctrl_regs
    import ohc_pkg::*;
#(
    parameter logic [7:0] SRST_CYCLES = OHC_SRST_CYCLES
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    // Register port
    input  wire logic [11:0] i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rd_data,
    output logic             o_target_abort,
    // Configuration space and strap inputs
    input  wire logic        i_suppress_abort_cfg,
    input  wire logic        i_eeprom_valid,
    input  wire logic        i_eeprom_lower_cfg,
    // PHY clock status pin
    input  wire logic        i_phy_clk_active,
    // Controller controls
    output logic             o_phy_comm_enable,
    output logic             o_phy_enhancement_use,
    output logic             o_posted_write_allow,
    output logic             o_link_connected,
    output logic             o_soft_reset,
    // Self-ID reception
    input  wire logic        i_selfid_start,
    input  wire logic        i_selfid_quadlet,
    output logic             o_selfid_wr_valid,
    output logic      [31:0] o_selfid_wr_addr
);

    ohc_state_type r;
    ohc_state_type r_nxt;
    ohc_selfid_if  sid_bus ();

    logic phy_range;
    logic busy;
    logic set_hit;
    logic clr_hit;
    logic srst_req;

    assign busy = (r.srst_state == OHC_SRST_BUSY);

    always_comb begin
        phy_range = ((i_addr >= OHC_PHY_LO1) && (i_addr <= OHC_PHY_HI1)) ||
                    ((i_addr >= OHC_PHY_LO2) && (i_addr <= OHC_PHY_HI2));
    end

    always_comb begin
        set_hit  = i_wr && (i_addr == OHC_CTRL_SET_OFS) && !busy;
        clr_hit  = i_wr && (i_addr == OHC_CTRL_CLR_OFS) && !busy;
        srst_req = set_hit && i_wr_data[OHC_BIT_SRST];

        r_nxt           = r;
        r_nxt.phy_sync1 = i_phy_clk_active;
        r_nxt.phy_sync2 = r.phy_sync1;
        r_nxt.abort     = 1'b0;
        r_nxt.rd_data   = OHC_ZERO;

        // Set and clear ports; zeros leave a bit alone
        if (set_hit) begin
            r_nxt.phy_enh = r.phy_enh | i_wr_data[OHC_BIT_PHY_ENH];
            r_nxt.link_power_status     = r.link_power_status     | i_wr_data[OHC_BIT_LPS];
            r_nxt.posted  = r.posted  | i_wr_data[OHC_BIT_POSTED];
            r_nxt.link_on = r.link_on | i_wr_data[OHC_BIT_LINK_ON];
        end
        if (clr_hit) begin
            r_nxt.phy_enh = r.phy_enh & ~i_wr_data[OHC_BIT_PHY_ENH];
            r_nxt.link_power_status     = r.link_power_status     & ~i_wr_data[OHC_BIT_LPS];
            r_nxt.posted  = r.posted  & ~i_wr_data[OHC_BIT_POSTED];
            r_nxt.link_on = r.link_on & ~i_wr_data[OHC_BIT_LINK_ON];
        end
        if (i_wr && (i_addr == OHC_BASE_OFS) && !busy) begin
            r_nxt.base = i_wr_data[31:OHC_BASE_LSB];
        end

        // Only the EEPROM strap or a hardware reset (which sets it) may change it; soft reset leaves it
        if (i_eeprom_valid) begin
            r_nxt.lower_cfg = i_eeprom_lower_cfg;
        end

        // Soft reset sequencing
        case (r.srst_state)
            OHC_SRST_IDLE: begin
                if (srst_req) begin
                    r_nxt.srst_state = OHC_SRST_BUSY;
                    r_nxt.srst_cnt   = SRST_CYCLES - 8'h01;
                end
            end
            OHC_SRST_BUSY: begin
                r_nxt.srst_cnt = r.srst_cnt - 8'h01;
                if (r.srst_cnt == 8'h00) begin
                    r_nxt.srst_state = OHC_SRST_IDLE;
                end
            end
            default: begin
                r_nxt.srst_state = OHC_SRST_IDLE;
            end
        endcase
        if (srst_req || busy) begin
            r_nxt.phy_enh = 1'b0;
            r_nxt.link_power_status     = 1'b0;
            r_nxt.posted  = 1'b0;
            r_nxt.link_on = 1'b0;
            r_nxt.base    = '0;
        end

        // Reads; the answer stands only in the following cycle
        if ((i_rd || i_wr) && phy_range && !r.phy_sync2) begin
            if (i_suppress_abort_cfg) begin
                r_nxt.rd_data = i_rd ? OHC_ALL_ONES : OHC_ZERO;
            end else begin
                r_nxt.abort = 1'b1;
            end
        end else if (i_rd) begin
            case (i_addr)
                OHC_CTRL_SET_OFS, OHC_CTRL_CLR_OFS: begin
                    r_nxt.rd_data                    = OHC_ZERO;
                    r_nxt.rd_data[OHC_BIT_LOWER_CFG] = r.lower_cfg;
                    r_nxt.rd_data[OHC_BIT_PHY_ENH]   = r.phy_enh;
                    r_nxt.rd_data[OHC_BIT_LPS]       = r.link_power_status;
                    r_nxt.rd_data[OHC_BIT_POSTED]    = r.posted;
                    r_nxt.rd_data[OHC_BIT_LINK_ON]   = r.link_on;
                    r_nxt.rd_data[OHC_BIT_SRST]      = busy;
                end
                OHC_BASE_OFS: begin
                    r_nxt.rd_data = {r.base, {OHC_BASE_LSB{1'b0}}};
                end
                default: begin
                    r_nxt.rd_data = OHC_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r           <= '0;
            r.lower_cfg <= OHC_LOWER_CFG_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // Link-PHY traffic gated by power status
    assign o_phy_comm_enable     = r.link_power_status && !busy;
    assign o_phy_enhancement_use = r.phy_enh;
    assign o_posted_write_allow  = r.posted;
    assign o_link_connected      = r.link_on && !busy;
    assign o_soft_reset          = busy;
    assign o_rd_data             = r.rd_data;
    assign o_target_abort        = r.abort;

    // Self-ID writer sees packets only while the link is connected
    assign sid_bus.base    = r.base;
    assign sid_bus.enable  = o_link_connected;
    assign sid_bus.flush   = busy;
    assign sid_bus.start   = i_selfid_start && o_link_connected;
    assign sid_bus.q_valid = i_selfid_quadlet && o_link_connected;

    ohc_selfid_addr u_selfid (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .sid       (sid_bus.gen)
    );

    assign o_selfid_wr_valid = sid_bus.wr_valid;
    assign o_selfid_wr_addr  = sid_bus.wr_addr;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_srst_start;
        i_wr && i_addr == OHC_CTRL_SET_OFS && i_wr_data[OHC_BIT_SRST] && !busy;
    endsequence

    sequence s_srst_busy;
        o_soft_reset[*8] ##1 !o_soft_reset;
    endsequence

    logic ctrl_rd;
    assign ctrl_rd = i_rd && (i_addr == OHC_CTRL_SET_OFS || i_addr == OHC_CTRL_CLR_OFS);

    chk_ctrl_rsvd_hi: assert property (ctrl_rd |=> o_rd_data[21:20] == 2'b00)
        else $error("control bits 21-20 not zero");

    chk_ctrl_rsvd_lo: assert property (ctrl_rd |=> o_rd_data[15:0] == 16'h0000)
        else $error("control bits 15-0 not zero");

    chk_phy_comm_gate: assert property (
        i_wr && i_addr == OHC_CTRL_CLR_OFS && i_wr_data[OHC_BIT_LPS] && !busy
        |=> !o_phy_comm_enable && o_rd_data == OHC_ZERO)
        else $error("PHY communication not blocked after power status cleared");

    chk_abort_clk_off: assert property (
        i_rd && phy_range && !r.phy_sync2 && !i_suppress_abort_cfg |=> o_target_abort)
        else $error("no target abort for PHY-domain access with clock off");

    chk_ones_suppressed: assert property (
        i_rd && phy_range && !r.phy_sync2 && i_suppress_abort_cfg
        |=> !o_target_abort && o_rd_data == OHC_ALL_ONES)
        else $error("suppressed access did not return all ones");

    chk_host_no_abort: assert property ((i_rd || i_wr) && !phy_range |=> !o_target_abort)
        else $error("abort on a host-clock register");

    chk_posted_follow: assert property (
        i_wr && i_addr == OHC_CTRL_SET_OFS && i_wr_data[OHC_BIT_POSTED] && !busy
        && !i_wr_data[OHC_BIT_SRST] |=> o_posted_write_allow)
        else $error("posted writes not enabled by bit 18");

    chk_link_off_srst: assert property (s_srst_start |=> !o_link_connected && !r.link_on)
        else $error("link enable survived software reset");

    chk_link_off_quiet: assert property (!o_link_connected |=> !o_selfid_wr_valid)
        else $error("self-ID write while link disconnected");

    chk_srst_busy_len: assert property (s_srst_start |=> s_srst_busy)
        else $error("software reset busy length wrong");

    chk_srst_restores: assert property (s_srst_start |=> !o_posted_write_allow && !o_phy_comm_enable
        && r.base == '0 && r.lower_cfg == $past(r.lower_cfg))
        else $error("software reset did not restore registers");

    chk_base_low_zero: assert property (i_rd && i_addr == OHC_BASE_OFS
        |=> o_rd_data[OHC_BASE_LSB-1:0] == '0)
        else $error("self-ID base low bits not zero");

    chk_eeprom_load: assert property (i_eeprom_valid |=> r.lower_cfg == $past(i_eeprom_lower_cfg))
        else $error("configured flag not loaded");

    chk_clear_link: assert property (
        i_wr && i_addr == OHC_CTRL_CLR_OFS && i_wr_data[OHC_BIT_LINK_ON] && !busy |=> !r.link_on)
        else $error("clear write did not clear link enable");

endmodule

// file: ohc_ctrl_regs_tb.sv
`timescale 1ns/100ps
module ohc_ctrl_regs_tb;
    import ohc_pkg::*;

    logic        i_ref_clk;
    logic        i_reset_n;
    logic [11:0] i_addr;
    logic [31:0] i_wr_data;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rd_data;
    logic        o_target_abort;
    logic        i_suppress_abort_cfg;
    logic        i_eeprom_valid;
    logic        i_eeprom_lower_cfg;
    logic        i_phy_clk_active;
    logic        o_phy_comm_enable;
    logic        o_phy_enhancement_use;
    logic        o_posted_write_allow;
    logic        o_link_connected;
    logic        o_soft_reset;
    logic        i_selfid_start;
    logic        i_selfid_quadlet;
    logic        o_selfid_wr_valid;
    logic [31:0] o_selfid_wr_addr;
    int          error_cnt;
    int          num_checks;
    int          cyc_cnt;
    int          srst_len;
    logic [11:0] phy_addr [6]  = '{12'h0D8, 12'h0DC, 12'h0F0, 12'h0F4, 12'h11C, 12'h120};
    logic        phy_in   [6]  = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [31:0] base_pat [2]  = '{32'hFFFFFFFF, 32'hA5A5A5A5};

    ohc_ctrl_regs u_ohc_ctrl_regs (
        .i_ref_clk             (i_ref_clk),
        .i_reset_n             (i_reset_n),
        .i_addr                (i_addr),
        .i_wr_data             (i_wr_data),
        .i_wr                  (i_wr),
        .i_rd                  (i_rd),
        .o_rd_data             (o_rd_data),
        .o_target_abort        (o_target_abort),
        .i_suppress_abort_cfg  (i_suppress_abort_cfg),
        .i_eeprom_valid        (i_eeprom_valid),
        .i_eeprom_lower_cfg    (i_eeprom_lower_cfg),
        .i_phy_clk_active      (i_phy_clk_active),
        .o_phy_comm_enable     (o_phy_comm_enable),
        .o_phy_enhancement_use (o_phy_enhancement_use),
        .o_posted_write_allow  (o_posted_write_allow),
        .o_link_connected      (o_link_connected),
        .o_soft_reset          (o_soft_reset),
        .i_selfid_start        (i_selfid_start),
        .i_selfid_quadlet      (i_selfid_quadlet),
        .o_selfid_wr_valid     (o_selfid_wr_valid),
        .o_selfid_wr_addr      (o_selfid_wr_addr)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Sampled answer lands one cycle after the strobe edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr      <= 1'b1;
        i_addr    <= a;
        i_wr_data <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_abort);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rd_data, exp);
        check({31'h0, o_target_abort}, {31'h0, exp_abort});
    endtask

    always @(posedge i_ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (o_soft_reset === 1'b1) begin
            srst_len <= srst_len + 1;
        end
        if (cyc_cnt == 5000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        {i_addr, i_wr_data, i_wr, i_rd, i_suppress_abort_cfg, i_eeprom_valid} = '0;
        {i_eeprom_lower_cfg, i_phy_clk_active, i_selfid_start, i_selfid_quadlet} = '0;
        {error_cnt, num_checks, cyc_cnt, srst_len} = '0;
        i_reset_n = 1'b0;
        repeat (8) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        rd_chk(OHC_CTRL_SET_OFS, 32'h00800000, 1'b0);
        rd_chk(OHC_BASE_OFS, 32'h0, 1'b0);
        // Ones except link, enhancement, bit 20 and soft reset; reserved and bit 23 must stay
        wr(OHC_CTRL_SET_OFS, 32'hFFACFFFF);
        // PHY clock settle time scaled down to a few cycles
        repeat (4) @(posedge i_ref_clk);
        wr(OHC_CTRL_SET_OFS, 32'h00020000);
        // Enhancements only once configured flag and link are both up
        wr(OHC_CTRL_SET_OFS, 32'h00400000);
        check({o_phy_enhancement_use, o_phy_comm_enable, o_posted_write_allow, o_link_connected}, 32'hF);
        rd_chk(OHC_CTRL_CLR_OFS, 32'h00CE0000, 1'b0);
        // Posted bit left alone while the link is up
        wr(OHC_CTRL_CLR_OFS, 32'h00880000);
        check({o_phy_comm_enable, o_posted_write_allow, o_link_connected}, 32'h3);
        rd_chk(OHC_CTRL_SET_OFS, 32'h00C60000, 1'b0);
        for (int p = 0; p < 2; p++) begin
            wr(OHC_BASE_OFS, base_pat[p]);
            rd_chk(OHC_BASE_OFS, base_pat[p] & 32'hFFFFF800, 1'b0);
        end
        // Self-ID stream lands at consecutive quadlets from the base
        @(posedge i_ref_clk);
        i_selfid_start <= 1'b1;
        @(posedge i_ref_clk);
        i_selfid_start   <= 1'b0;
        i_selfid_quadlet <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(posedge i_ref_clk);
            if (k == 2) begin
                i_selfid_quadlet <= 1'b0;
            end
            #1;
            check({31'h0, o_selfid_wr_valid}, 32'h1);
            check(o_selfid_wr_addr, 32'hA5A5A000 + 32'(4 * k));
        end
        wr(OHC_CTRL_CLR_OFS, 32'h00020000);
        i_selfid_quadlet <= 1'b1;
        @(posedge i_ref_clk);
        i_selfid_quadlet <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        check({31'h0, o_selfid_wr_valid}, 32'h0);
        // Soft reset with link up; a write during busy must be dropped
        wr(OHC_CTRL_SET_OFS, 32'h000E0000);
        srst_len = 0;
        wr(OHC_CTRL_SET_OFS, 32'h00010000);
        check({o_soft_reset, o_link_connected, o_phy_comm_enable}, 32'h4);
        rd_chk(OHC_CTRL_SET_OFS, 32'h00810000, 1'b0);
        wr(OHC_CTRL_SET_OFS, 32'h00020000);
        for (int w = 0; w < 50 && o_soft_reset !== 1'b0; w++) begin
            @(posedge i_ref_clk);
        end
        #1;
        check(32'(srst_len), 32'(OHC_SRST_CYCLES));
        rd_chk(OHC_CTRL_SET_OFS, 32'h00800000, 1'b0);
        rd_chk(OHC_BASE_OFS, 32'h0, 1'b0);
        // Strap reload of the configured flag
        @(posedge i_ref_clk);
        i_eeprom_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_eeprom_valid <= 1'b0;
        rd_chk(OHC_CTRL_SET_OFS, 32'h0, 1'b0);
        // PHY clock off: abort, then all-ones when suppressed
        for (int s = 0; s < 2; s++) begin
            i_suppress_abort_cfg <= s[0];
            for (int j = 0; j < 6; j++) begin
                rd_chk(phy_addr[j], (s == 1 && phy_in[j]) ? OHC_ALL_ONES : OHC_ZERO, s == 0 && phy_in[j]);
            end
        end
        i_suppress_abort_cfg <= 1'b0;
        wr(OHC_PHY_LO2, 32'h12345678);
        check({31'h0, o_target_abort}, 32'h1);
        i_phy_clk_active <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        rd_chk(OHC_PHY_LO1, 32'h0, 1'b0);
        rd_chk(12'h200, 32'h0, 1'b0);
        // Hardware reset in mid-run drops the link
        wr(OHC_CTRL_SET_OFS, 32'h00020000);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        #1;
        check({31'h0, o_link_connected}, 32'h0);
        rd_chk(OHC_CTRL_SET_OFS, 32'h00800000, 1'b0);
        check({31'h0, o_link_connected}, 32'h0);
        summarize();
    end
endmodule
